/* File: mvdc_defines.svh */
/*
 * Constants of the data-move space controller: register indices, field
 * positions, reset values, size codes and timing figures.
 * Assumes inclusion by bare name from every file that needs a number.
 */
`ifndef MVDC_DEFINES_SVH
`define MVDC_DEFINES_SVH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define MVDC_AUX_IDX 8'h8E
`define MVDC_EECTL_IDX 8'hD2
`define MVDC_AUX_RST 8'h08
`define MVDC_AUX_WMASK 8'hBF
`define MVDC_EEC_MAP_EN 1
`define MVDC_EEC_PROG 0

// ---------------------------------------------------------------
// security byte fields and address map
// ---------------------------------------------------------------
`define MVDC_SEC_X2 7
`define MVDC_SEC_RAM 3
`define MVDC_EE_LAST 16'h07FF
`define MVDC_XRS_256 3'h0
`define MVDC_XRS_512 3'h1
`define MVDC_XRS_768 3'h2
`define MVDC_XRS_1024 3'h3
`define MVDC_XRS_1792 3'h4
`define MVDC_SZ_256 16'h0100
`define MVDC_SZ_512 16'h0200
`define MVDC_SZ_768 16'h0300
`define MVDC_SZ_1024 16'h0400
`define MVDC_SZ_1792 16'h0700
`define MVDC_ERASED 8'hFF

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define MVDC_ALE_DIV_STD 3'h6
`define MVDC_ALE_DIV_X2 3'h3
`define MVDC_STROBE_SHORT 5'h06
`define MVDC_STROBE_LONG 5'h1E
`define MVDC_CLK_PERIOD_NS 20
`define MVDC_EE_PROG_TIME_NS 10000000
`define MVDC_RESP_OKAY 2'h0
`define MVDC_RESP_SLVERR 2'h2

`endif

/* File: mvdc_pkg.sv */
/*
 * Types of the data-move space controller.
 * Assumes the constants header is compiled alongside.
 */
package mvdc_pkg;

   // auxiliary control register layout
   typedef struct packed {
      logic pullup_off;
      logic rsvd;
      logic strobe_stretch;
      logic [2:0] expanded_ram_size_sel;
      logic ext_data_select;
      logic latch_quiet;
   } mvdc_aux_s;

   // one data move from the core
   typedef struct packed {
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } mvdc_move_s;

   typedef enum logic [1:0] {MVDC_T_EXPANDED_RAM, MVDC_T_EE, MVDC_T_EXT} mvdc_target_e;

   typedef enum logic [1:0] {MVDC_IDLE, MVDC_ALE, MVDC_STROBE} mvdc_state_e;

endpackage : mvdc_pkg

/* File: mvdc_strobe_timer.sv */
/*
 * Read/write strobe width timer: active for 6 or 30 cycles after start.
 * Assumes start arrives only while not active.
 */
`timescale 1ns/10ps
`include "mvdc_defines.svh"

module mvdc_strobe_timer
   import mvdc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic start,
   input wire logic long_sel,
   output logic active,
   output wire logic last
);

   logic [4:0] cnt_r;
   wire logic [4:0] width = long_sel ? `MVDC_STROBE_LONG : `MVDC_STROBE_SHORT;

   // last cycle of the strobe
   assign last = active && (cnt_r == 5'h00);

   // count the strobe down from its width
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         active <= 1'b0;
         cnt_r <= 5'h00;
      end else if (start) begin
         active <= 1'b1;
         cnt_r <= width - 5'h01;
      end else if (active) begin
         active <= (cnt_r != 5'h00);
         cnt_r <= cnt_r - 5'h01;
      end
   end

endmodule : mvdc_strobe_timer

/* File: mvdc_top.sv */
/*
 * Data-move space controller: steers core data moves to expanded RAM,
 * the 2 KB EEPROM or the multiplexed external bus; registers on AXI4-Lite.
 * Assumes aclk is the oscillator and the security byte is steady at reset.
 */
// Notes on behaviour
// - EEPROM sits at 0000h-07FFh, reached only while the map bit is set.
// - EEPROM reads and writes come only as data moves.
// - EEPROM is written one byte per data-move store.
// - an EEPROM store raises busy; EEPROM moves are refused while busy.
// - busy clears when programming time has elapsed.
// - latch strobe marks the address phase of each external access.
// - quiet bit stops the strobe except during accesses and fetches.
// - a suppressed latch pin is held high by weak pull-up only.
// - quiet clear: strobe every 6 clocks, every 3 in double speed.
// - stretch bit sets read/write strobe to 6 or 30 clocks.
// - size code 001/010/011/100 gives 512/768/1024/1792 bytes.
// - select bit clear uses on-chip RAM, set uses external memory.
// - select bit loads from the security byte after power-up.
// - pull-up-off bit disables the weak port pull-ups.
// - map bit set targets EEPROM, clear targets expanded RAM.
// - busy flag is hardware only; software cannot change it.
// - programmed security bit inhibits on-chip expanded RAM.
`timescale 1ns/10ps
`include "mvdc_defines.svh"

module mvdc_top
   import mvdc_pkg::*;
#(
   parameter int EXPANDED_RAM_BYTES = 1792,
   parameter int EE_BYTES = 2048,
   parameter int EE_PROG_CYCLES = `MVDC_EE_PROG_TIME_NS / `MVDC_CLK_PERIOD_NS
)(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] hw_security_byte,
   input wire logic ext_fetch_active,
   input wire logic mv_valid,
   input wire mvdc_move_s mv_req,
   output logic mv_ready,
   output logic mv_done,
   output logic mv_blocked,
   output logic [7:0] mv_rdata,
   output logic ale,
   output logic ale_oe,
   output logic ale_weak_pullup,
   output logic rd_n,
   output logic wr_n,
   input wire logic [7:0] p0_in,
   output logic [7:0] p0_out,
   output logic p0_oe,
   output logic [7:0] p2_out,
   output logic port_pullup_en
);

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   if (EXPANDED_RAM_BYTES < 256 || EXPANDED_RAM_BYTES > 1792 || EE_BYTES != 2048
       || EE_PROG_CYCLES < 2 || EE_PROG_CYCLES > 16777215) begin : g_chk
      $error("mvdc_top: unsupported parameter value");
   end

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   // byte address of a register index
   function automatic logic [11:0] reg_addr(input logic [7:0] idx);
      reg_addr = {2'b00, idx, 2'b00};
   endfunction : reg_addr

   // on-chip expanded RAM size for a size code
   function automatic logic [15:0] expanded_ram_limit(input logic [2:0] sel);
      case (sel)
         `MVDC_XRS_256: expanded_ram_limit = `MVDC_SZ_256;
         `MVDC_XRS_512: expanded_ram_limit = `MVDC_SZ_512;
         `MVDC_XRS_768: expanded_ram_limit = `MVDC_SZ_768;
         `MVDC_XRS_1024: expanded_ram_limit = `MVDC_SZ_1024;
         `MVDC_XRS_1792: expanded_ram_limit = `MVDC_SZ_1792;
         default: expanded_ram_limit = `MVDC_SZ_1792;
      endcase
   endfunction : expanded_ram_limit

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   mvdc_aux_s aux_r;
   logic map_en_r, ee_busy_r, strap_done_r, x2_mode_r, expanded_ram_inhibit_r;
   logic [23:0] prog_cnt_r;
   logic [2:0] div_cnt_r;
   mvdc_state_e st_r;
   mvdc_move_s cur_r;
   logic aw_got_r, w_got_r;
   logic [11:0] aw_addr_r;
   logic [7:0] w_byte_r;
   logic w_lane_r;
   logic [7:0] expanded_ram_mem [EXPANDED_RAM_BYTES];
   logic [7:0] ee_mem [EE_BYTES];
   logic tmr_active, tmr_last;

   // ---------------------------------------------------------------
   // move decode
   // ---------------------------------------------------------------
   wire logic accept = mv_valid && mv_ready;
   wire logic in_ee = mv_req.addr <= `MVDC_EE_LAST;
   wire logic [15:0] xlim = expanded_ram_limit(aux_r.expanded_ram_size_sel);
   wire logic in_expanded_ram = (mv_req.addr < xlim) && !aux_r.ext_data_select
                        && !expanded_ram_inhibit_r;
   wire mvdc_target_e tgt = (map_en_r && in_ee) ? MVDC_T_EE :
                            in_expanded_ram ? MVDC_T_EXPANDED_RAM : MVDC_T_EXT;
   wire logic ee_acc = accept && (tgt == MVDC_T_EE);
   wire logic ee_refuse = ee_acc && ee_busy_r;
   wire logic ee_wr = ee_acc && !ee_busy_r && mv_req.write;
   wire logic xr_acc = accept && (tgt == MVDC_T_EXPANDED_RAM);
   wire logic ext_acc = accept && (tgt == MVDC_T_EXT);
   wire logic [10:0] mem_idx = mv_req.addr[10:0];
   wire logic [7:0] int_rdata = (tgt == MVDC_T_EE) ? ee_mem[mem_idx]
                                : expanded_ram_mem[mem_idx];

   // ---------------------------------------------------------------
   // register bus decode
   // ---------------------------------------------------------------
   wire logic wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
   wire logic wr_aux = wr_fire && w_lane_r
                       && aw_addr_r == reg_addr(`MVDC_AUX_IDX);
   wire logic wr_eec = wr_fire && w_lane_r
                       && aw_addr_r == reg_addr(`MVDC_EECTL_IDX);
   wire logic wr_hit = aw_addr_r == reg_addr(`MVDC_AUX_IDX)
                       || aw_addr_r == reg_addr(`MVDC_EECTL_IDX);
   wire logic rd_fire = s_axi_arvalid && s_axi_arready;
   wire logic rd_aux = s_axi_araddr == reg_addr(`MVDC_AUX_IDX);
   wire logic rd_eec = s_axi_araddr == reg_addr(`MVDC_EECTL_IDX);
   wire logic [7:0] eec_view = {6'h00, map_en_r, ee_busy_r};
   wire logic [7:0] rd_byte = rd_aux ? (aux_r & `MVDC_AUX_WMASK)
                              : rd_eec ? eec_view : 8'h00;

   // ---------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         aw_addr_r <= 12'h000;
         w_byte_r <= 8'h00;
         w_lane_r <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `MVDC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            w_byte_r <= s_axi_wdata[7:0];
            w_lane_r <= s_axi_wstrb[0];
         end
         if (wr_fire) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `MVDC_RESP_OKAY : `MVDC_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ready while the matching holding slot is empty
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_got_r && !(s_axi_awvalid && s_axi_awready)
                          && !wr_fire;
         s_axi_wready <= !w_got_r && !(s_axi_wvalid && s_axi_wready)
                         && !wr_fire;
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `MVDC_RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rd_byte};
         s_axi_rresp <= (rd_aux || rd_eec) ? `MVDC_RESP_OKAY
                        : `MVDC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end else begin
         s_axi_arready <= !s_axi_rvalid;
      end
   end

   // ---------------------------------------------------------------
   // control registers and strap capture
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aux_r <= `MVDC_AUX_RST;
         map_en_r <= 1'b0;
         strap_done_r <= 1'b0;
         x2_mode_r <= 1'b0;
         expanded_ram_inhibit_r <= 1'b0;
      end else begin
         if (wr_aux)
            aux_r <= w_byte_r & `MVDC_AUX_WMASK;
         if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            x2_mode_r <= !hw_security_byte[`MVDC_SEC_X2];
            expanded_ram_inhibit_r <= !hw_security_byte[`MVDC_SEC_RAM];
            aux_r.ext_data_select <= !hw_security_byte[`MVDC_SEC_RAM];
         end
         if (wr_eec)
            map_en_r <= w_byte_r[`MVDC_EEC_MAP_EN];   // busy bit not taken
      end
   end

   // ---------------------------------------------------------------
   // EEPROM programming timer and busy flag
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ee_busy_r <= 1'b0;
         prog_cnt_r <= 24'h00_0000;
      end else if (ee_wr) begin
         ee_busy_r <= 1'b1;
         prog_cnt_r <= 24'(EE_PROG_CYCLES);
      end else if (ee_busy_r) begin
         prog_cnt_r <= prog_cnt_r - 24'h00_0001;
         ee_busy_r <= (prog_cnt_r != 24'h00_0001);
      end
   end

   // on-chip storage written by data moves only
   always_ff @(posedge aclk) begin
      if (ee_wr)
         ee_mem[mem_idx] <= mv_req.wdata;
      if (xr_acc && mv_req.write)
         expanded_ram_mem[mem_idx] <= mv_req.wdata;
   end

   // ---------------------------------------------------------------
   // data-move sequencer
   // ---------------------------------------------------------------
   mvdc_strobe_timer u_strobe (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(st_r == MVDC_ALE),
      .long_sel(aux_r.strobe_stretch),
      .active(tmr_active),
      .last(tmr_last)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= MVDC_IDLE;
         cur_r <= '0;
         mv_ready <= 1'b0;
         mv_done <= 1'b0;
         mv_blocked <= 1'b0;
         mv_rdata <= 8'h00;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         p0_out <= 8'h00;
         p0_oe <= 1'b0;
         p2_out <= 8'h00;
      end else begin
         mv_done <= 1'b0;
         mv_blocked <= 1'b0;
         case (st_r)
            MVDC_IDLE: begin
               mv_ready <= !accept;
               if (ext_acc) begin
                  st_r <= MVDC_ALE;
                  cur_r <= mv_req;
                  p0_out <= mv_req.addr[7:0];
                  p0_oe <= 1'b1;
                  p2_out <= mv_req.addr[15:8];
               end else if (accept) begin
                  mv_done <= 1'b1;
                  mv_blocked <= ee_refuse;
                  mv_rdata <= ee_refuse ? `MVDC_ERASED : int_rdata;
               end
            end
            MVDC_ALE: begin
               st_r <= MVDC_STROBE;
               rd_n <= cur_r.write;
               wr_n <= !cur_r.write;
               p0_out <= cur_r.wdata;
               p0_oe <= cur_r.write;
            end
            MVDC_STROBE: begin
               if (tmr_last) begin
                  st_r <= MVDC_IDLE;
                  rd_n <= 1'b1;
                  wr_n <= 1'b1;
                  p0_oe <= 1'b0;
                  mv_done <= 1'b1;
                  mv_ready <= 1'b1;
                  mv_rdata <= cur_r.write ? 8'h00 : p0_in;
               end
            end
            default: st_r <= MVDC_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // address latch strobe and pull-ups
   // ---------------------------------------------------------------
   wire logic [2:0] ale_div = x2_mode_r ? `MVDC_ALE_DIV_X2 : `MVDC_ALE_DIV_STD;
   wire logic ale_tick = div_cnt_r == 3'h0;
   wire logic ale_run = !aux_r.latch_quiet || ext_fetch_active;
   wire logic ale_nxt = (ale_tick && ale_run) || ext_acc;
   wire logic ale_keep = ale_run || st_r != MVDC_IDLE || ext_acc;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt_r <= 3'h0;
         ale <= 1'b0;
         ale_oe <= 1'b0;
         ale_weak_pullup <= 1'b1;
         port_pullup_en <= 1'b1;
      end else begin
         div_cnt_r <= (div_cnt_r >= ale_div - 3'h1) ? 3'h0
                      : div_cnt_r + 3'h1;
         ale <= ale_nxt;
         ale_oe <= ale_keep;
         ale_weak_pullup <= !ale_keep;
         port_pullup_en <= !aux_r.pullup_off;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   busy_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ee_wr |=> ee_busy_r ##1 ee_busy_r) else $error("busy not raised");
   ee_refused_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ee_acc && ee_busy_r |=> mv_done && mv_blocked)
      else $error("busy EEPROM move not refused");
   busy_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(ee_busy_r) |-> $past(prog_cnt_r) == 24'h00_0001)
      else $error("busy cleared early");
   busy_hw_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(ee_busy_r) |-> $past(ee_wr)) else $error("busy set without store");
   ale_rate_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ale_tick && !x2_mode_r && strap_done_r |=> !ale_tick[*5] ##1 ale_tick)
      else $error("latch period wrong");
   ale_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
      aux_r.latch_quiet && !ext_fetch_active && !ext_acc |=> !ale)
      else $error("latch toggles while quiet");
   strobe_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(rd_n) && !aux_r.strobe_stretch |-> !rd_n[*6] ##1 rd_n)
      else $error("read strobe width wrong");
   expanded_ram_size_a: assert property (@(posedge aclk) disable iff (!aresetn)
      xr_acc |-> mv_req.addr < expanded_ram_limit(aux_r.expanded_ram_size_sel))
      else $error("expanded RAM hit beyond size");
   ext_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
      accept && aux_r.ext_data_select && !map_en_r |=> st_r == MVDC_ALE && ale)
      else $error("external select not honoured");

endmodule : mvdc_top

/* File: mvdc_ext_ram.sv */
/*
 * external byte memory model on the multiplexed port 0 bus.
 * assumes the latch strobe marks the address phase, strobes active low.
 */
`timescale 1ns/10ps

module mvdc_ext_ram (
   input wire logic aclk,
   input wire logic ale,
   input wire logic [7:0] p0_out,
   input wire logic p0_oe,
   input wire logic [7:0] p2_out,
   input wire logic rd_n,
   input wire logic wr_n,
   output logic [7:0] p0_in = 8'h00
);
   logic [7:0] mem [int];
   logic [15:0] addr_r = 16'h0000;
   // latch the address phase, store while the write strobe is low
   always @(posedge aclk) begin
      if (ale && p0_oe && rd_n && wr_n)
         addr_r <= {p2_out, p0_out};
      if (!wr_n && p0_oe)
         mem[addr_r] = p0_out;
   end
   // answer a cycle into the read strobe; a released bus keeps changing
   always @(posedge aclk) begin
      if (!rd_n)
         p0_in <= mem.exists(addr_r) ? mem[addr_r] : 8'hA5;
      else
         p0_in <= ~p0_in;
   end
endmodule : mvdc_ext_ram

/* File: test_ext_data_move_data_space_control.sv */
/*
 * self-checking bench of the data-move space controller.
 * assumes the package, header, design files and the memory model.
 */
`timescale 1ns/10ps

module test_ext_data_move_data_space_control
   import mvdc_pkg::*;
();
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, mv_valid = 1'b0;
   logic ext_fetch_active = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, mv_ready, mv_done, mv_blocked, ale, ale_oe;
   logic ale_weak_pullup, rd_n, wr_n, p0_oe, port_pullup_en;
   logic [7:0] hw_security_byte = 8'hFF, mv_rdata, p0_in, p0_out, p2_out;
   mvdc_move_s mv_req = '0;
   int err_count = 0, n_tests = 0, sz = 768, p, q;
   int szs [5] = '{256, 512, 768, 1024, 1792};
   logic [31:0] seed = 32'h2A89486F;
   logic [7:0] mdl [int];
   logic map_on = 1'b0, ext = 1'b0, inh = 1'b0, st = 1'b0;

   // 50 MHz clock
   always #10 aclk = ~aclk;

   mvdc_top #(.EE_PROG_CYCLES(20)) u_dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .hw_security_byte, .ext_fetch_active,
      .mv_valid, .mv_req, .mv_ready, .mv_done, .mv_blocked, .mv_rdata,
      .ale, .ale_oe, .ale_weak_pullup, .rd_n, .wr_n, .p0_in, .p0_out,
      .p0_oe, .p2_out, .port_pullup_en);
   mvdc_ext_ram u_ram (.aclk, .ale, .p0_out, .p0_oe, .p2_out, .rd_n,
      .wr_n, .p0_in);

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic close_out();
      if (err_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic to(input string nm);
      err_count++;
      $display("mismatch %s expected answer seen timeout", nm);
      close_out();
   endtask : to

   function automatic logic [7:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : xs

   task automatic rst(input logic [7:0] h);
      hw_security_byte <= h;
      aresetn <= 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
   endtask : rst

   // register write: address and data offered together
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic pa = 1'b1, pw = 1'b1;
      int n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (pa || pw) begin
         @(negedge aclk);
         if (s_axi_awready === 1'b1) pa = 1'b0;
         if (s_axi_wready === 1'b1) pw = 1'b0;
         if (++n > 50) to("write");
         @(posedge aclk);
         if (!pa) s_axi_awvalid <= 1'b0;
         if (!pw) s_axi_wvalid <= 1'b0;
      end
      do begin
         @(negedge aclk);
         if (++n > 100) to("write answer");
      end while (s_axi_bvalid !== 1'b1);
      chk("write response", s_axi_bresp, 2'h0);
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask : wr

   // register read compared with the expected word and response
   task automatic creg(input logic [11:0] a, input logic [31:0] e,
         input logic [1:0] er);
      int n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         if (++n > 50) to("read");
      end while (s_axi_arready !== 1'b1);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do begin
         @(negedge aclk);
         if (++n > 100) to("read answer");
      end while (s_axi_rvalid !== 1'b1);
      chk("register data", s_axi_rdata, e);
      chk("register response", s_axi_rresp, er);
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask : creg

   // one data move; target and strobe length worked out from the map
   task automatic mv(input logic w, input logic [15:0] a, input logic bl);
      int n = 0, s = 0, k, key;
      logic [7:0] d = xs();
      k = (map_on && a <= 16'h07FF) ? 2 : (!ext && !inh && a < sz) ? 0 : 1;
      key = k * 65536 + a;
      mv_req <= '{w, a, d};
      mv_valid <= 1'b1;
      do begin
         @(negedge aclk);
         if (++n > 50) to("move take");
      end while (mv_ready !== 1'b1);
      @(posedge aclk);
      mv_valid <= 1'b0;
      do begin
         @(negedge aclk);
         if (!rd_n || !wr_n) s++;
         if (++n > 150) to("move done");
      end while (mv_done !== 1'b1);
      chk("move refused", mv_blocked, bl);
      chk("strobe cycles", s, k == 1 ? (st ? 30 : 6) : 0);
      if (k == 1) chk("high address", p2_out, a[15:8]);
      if (w && !bl) mdl[key] = d;
      if (!w) chk("move data", mv_rdata, bl ? 8'hFF : mdl[key]);
      @(posedge aclk);
   endtask : mv

   task automatic rwm(input logic [15:0] a);
      mv(1'b1, a, 1'b0);
      mv(1'b0, a, 1'b0);
   endtask : rwm

   // count latch pulses and cycles without the weak pull-up
   task automatic alec();
      p = 0;
      q = 0;
      repeat (60) begin
         @(negedge aclk);
         if (ale === 1'b1) p++;
         if (ale_weak_pullup !== 1'b1) q++;
      end
      @(posedge aclk);
   endtask : alec

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rst(8'hFF);
      creg(12'h238, 32'h08, 2'h0);
      creg(12'h348, 32'h00, 2'h0);
      creg(12'h100, 32'h00, 2'h2);
      chk("pull-ups", port_pullup_en, 1'b1);
      wr(12'h238, 8'h88);
      alec();
      chk("latch pulses", p, 10);
      chk("pull-ups", port_pullup_en, 1'b0);
      wr(12'h238, 8'h09);
      alec();
      chk("latch pulses", p, 0);
      chk("weak pull-up", q, 0);
      chk("latch drive", ale_oe, 1'b0);
      ext_fetch_active <= 1'b1;
      alec();
      chk("latch in fetch", p > 0, 1'b1);
      ext_fetch_active <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         sz = szs[i];
         wr(12'h238, {3'b000, i[2:0], 2'b00});
         rwm(16'(sz - 1));
         rwm(16'(sz));
      end
      sz = 768;
      wr(12'h238, 8'h28);
      st = 1'b1;
      rwm(16'h1234);
      st = 1'b0;
      wr(12'h238, 8'h0A);
      ext = 1'b1;
      rwm(16'h0010);
      ext = 1'b0;
      wr(12'h238, 8'h08);
      wr(12'h348, 8'h02);
      map_on = 1'b1;
      mv(1'b1, 16'h07FF, 1'b0);
      mv(1'b0, 16'h07FF, 1'b1);
      wr(12'h348, 8'h02);
      creg(12'h348, 32'h03, 2'h0);
      repeat (30) @(posedge aclk);
      creg(12'h348, 32'h02, 2'h0);
      mv(1'b0, 16'h07FF, 1'b0);
      wr(12'h348, 8'h00);
      map_on = 1'b0;
      mv(1'b0, 16'h02FF, 1'b0);
      rst(8'h77);
      inh = 1'b1;
      ext = 1'b1;
      creg(12'h238, 32'h0A, 2'h0);
      alec();
      chk("latch pulses", p, 20);
      rwm(16'h0005);
      close_out();
   end
endmodule : test_ext_data_move_data_space_control
